//--- tb/mac_station_address_hash_filter_tb.sv
/*
 * Self-checking bench of the station address and group hash filter.
 * Assumes the design package, design sources and EEPROM model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module mac_station_address_hash_filter_tb;
    localparam logic [3:0] STS = msahf_pkg::IDX_STATUS;
    localparam logic [3:0] CTL = msahf_pkg::IDX_CONTROL;
    localparam logic [3:0] SAU = msahf_pkg::IDX_SA_UPPER;
    localparam logic [3:0] SAL = msahf_pkg::IDX_SA_LOWER;
    localparam logic [3:0] GFU = msahf_pkg::IDX_GF_UPPER;
    localparam logic [3:0] GFL = msahf_pkg::IDX_GF_LOWER;
    localparam logic [31:0] RX_ON = 32'h1 << msahf_pkg::CTRL_RX_ON_BIT;
    localparam logic [31:0] PASS = 32'h1 << msahf_pkg::CTRL_PASS_ALL_BIT;
    localparam logic [47:0] STA = 48'hbc9a78563412;
    localparam logic [47:0] GRP = 48'h0100005e0001;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h0;
    logic rx_first = 1'b0;
    logic rx_last = 1'b0;
    logic res_ready = 1'b0;
    logic ee_start = 1'b0;
    logic ee_prog = 1'b0;
    logic hreadyout, hresp, init_done, mac_receiver_on, rx_ready, res_valid, res_accept;
    logic ee_valid, ee_programmed, ee_done;
    logic [7:0] ee_addr, ee_data;
    logic [31:0] hrdata;
    logic [5:0] res_hash_index;
    logic [47:0] res_dest_addr;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    msahf_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ee_valid(ee_valid), .ee_addr(ee_addr), .ee_data(ee_data),
        .ee_programmed(ee_programmed), .ee_done(ee_done), .init_done(init_done),
        .mac_receiver_on(mac_receiver_on), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last), .res_valid(res_valid),
        .res_ready(res_ready), .res_accept(res_accept), .res_hash_index(res_hash_index),
        .res_dest_addr(res_dest_addr));

    msahf_ee_model ee_u (.hclk(hclk), .hresetn(hresetn), .start(ee_start),
        .programmed(ee_prog), .image(STA), .ee_valid(ee_valid), .ee_addr(ee_addr),
        .ee_data(ee_data), .ee_programmed(ee_programmed), .ee_done(ee_done));

    initial begin
        forever #2.5 hclk = ~hclk;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Reflected CRC-32 over the six address bytes, first wire bit first.
    function automatic logic [5:0] hash_of(input logic [47:0] da);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < 48; i++) begin
            c = (c[0] ^ da[i]) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
        end
        return c[31:26];
    endfunction : hash_of

    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : do_reset

    task automatic ahb_xfer(input logic w_en, input logic [3:0] idx, input logic [31:0] wd,
                            output logic [31:0] rd);
        int w;
        w = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w_en;
        haddr <= {26'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1 && w++ < 100);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w_en ? wd : ~wd;
        do @(posedge hclk); while (hreadyout !== 1'b1 && w++ < 100);
        rd = hrdata;
        if (w >= 100) n_errors++;
    endtask : ahb_xfer

    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] x;
        ahb_xfer(1'b1, idx, d, x);
    endtask : wr

    task automatic rd_chk(input string what, input logic [3:0] idx, input logic [31:0] e);
        logic [31:0] x;
        ahb_xfer(1'b0, idx, 32'h0, x);
        check(what, {16'h0, x}, {16'h0, e});
    endtask : rd_chk

    task automatic ee_load(input logic prog);
        int w;
        w = 0;
        ee_prog <= prog;
        ee_start <= 1'b1;
        @(posedge hclk);
        ee_start <= 1'b0;
        do @(posedge hclk); while (init_done !== 1'b1 && w++ < 100);
        check("init_done", {47'h0, init_done}, 48'h1);
    endtask : ee_load

    task automatic send_byte(input logic [7:0] b, input logic f, input logic l);
        int w;
        w = 0;
        rx_valid <= 1'b1;
        rx_data <= b;
        rx_first <= f;
        rx_last <= l;
        do @(posedge hclk); while (rx_ready !== 1'b1 && w++ < 200);
        if (w >= 200) n_errors++;
    endtask : send_byte

    task automatic send_frame(input logic [47:0] da);
        for (int k = 0; k < 6; k++) begin
            send_byte(da[8 * k +: 8], k == 0, k == 5);
        end
        rx_valid <= 1'b0;
        rx_data <= ~da[47:40];
    endtask : send_frame

    task automatic get_res(input logic acc, input logic [47:0] da);
        int w;
        w = 0;
        do @(posedge hclk); while (res_valid !== 1'b1 && w++ < 50);
        check("res_valid", {47'h0, res_valid}, 48'h1);
        check("accept", {47'h0, res_accept}, {47'h0, acc});
        check("dest", res_dest_addr, da);
        if (da[0]) check("index", {42'h0, res_hash_index}, {42'h0, hash_of(da)});
        res_ready <= 1'b1;
        @(posedge hclk);
        res_ready <= 1'b0;
    endtask : get_res

    initial begin
        logic [5:0] h;
        int n;
        int m;
        do_reset();
        rd_chk("sa_upper", SAU, 32'h0000ffff);
        rd_chk("sa_lower", SAL, 32'h0fffffff);
        rd_chk("gf_upper", GFU, 32'h0);
        rd_chk("gf_lower", GFL, 32'h0);
        wr(4'h6, 32'h12345678);
        rd_chk("unmapped", 4'h6, 32'h0);
        ee_load(1'b0);
        rd_chk("status_unprog", STS, 32'h00000001);
        rd_chk("sa_lower", SAL, 32'h0fffffff);
        do_reset();
        ee_load(1'b1);
        rd_chk("status_prog", STS, 32'h00000003);
        rd_chk("sa_lower", SAL, 32'h78563412);
        rd_chk("sa_upper", SAU, 32'h0000bc9a);
        wr(SAU, 32'hffff1234);
        rd_chk("sa_upper", SAU, 32'h00001234);
        wr(SAU, 32'h0000bc9a);
        send_frame(STA);
        repeat (12) @(posedge hclk);
        check("rx_off", {47'h0, res_valid}, 48'h0);
        wr(CTL, RX_ON);
        repeat (2) @(posedge hclk);
        check("rx_on", {47'h0, mac_receiver_on}, 48'h1);
        send_frame(STA);
        get_res(1'b1, STA);
        send_frame(STA ^ 48'h010000000000);
        get_res(1'b0, STA ^ 48'h010000000000);
        send_frame(48'h123456789abc);
        get_res(1'b0, 48'h123456789abc);
        h = hash_of(GRP);
        send_frame(GRP);
        get_res(1'b0, GRP);
        wr(h[5] ? GFU : GFL, 32'h1 << h[4:0]);
        send_frame(GRP);
        get_res(1'b1, GRP);
        wr(h[5] ? GFL : GFU, 32'hffffffff);
        wr(h[5] ? GFU : GFL, ~(32'h1 << h[4:0]));
        send_frame(GRP);
        get_res(1'b0, GRP);
        rd_chk("gf_other", h[5] ? GFL : GFU, 32'hffffffff);
        wr(CTL, RX_ON | PASS);
        rd_chk("control", CTL, RX_ON | PASS);
        send_frame(GRP);
        get_res(1'b1, GRP);
        n = 0;
        do begin
            send_frame(STA);
            n++;
            repeat (12) @(posedge hclk);
        end while (rx_ready === 1'b1 && n < 40);
        check("rx_ready_full", {47'h0, rx_ready}, 48'h0);
        check("fill_depth", {47'h0, n > 32}, 48'h1);
        rd_chk("status_stall", STS, 32'h00000007);
        m = 0;
        res_ready <= 1'b1;
        repeat (150) begin
            @(posedge hclk);
            if (res_valid === 1'b1) m++;
        end
        res_ready <= 1'b0;
        check("drained", 48'(m), 48'(n));
        check("hresp", {47'h0, hresp}, 48'h0);
        end_sim();
    end
endmodule : mac_station_address_hash_filter_tb
`default_nettype wire

//--- tb/msahf_ee_model.sv
/*
 * Behavioural EEPROM controller that offers the station address bytes at power-on.
 * Assumes one clock, an active-low reset and a start pulse from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module msahf_ee_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic programmed,
    input wire logic [47:0] image,
    output logic ee_valid,
    output logic [7:0] ee_addr,
    output logic [7:0] ee_data,
    output logic ee_programmed,
    output logic ee_done
);
    logic [3:0] step;
    logic [2:0] a;
    assign ee_programmed = programmed;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step <= 4'h0;
        end else if (step != 4'h0 || start) begin
            step <= step + 4'h1;
        end
    end
    // Odd steps offer addresses 1 to 7 with an idle cycle between them.
    always_comb begin
        a = 3'((step + 4'h1) >> 1);
        ee_valid = step[0] && (step != 4'hf);
        ee_done = (step == 4'he);
        ee_addr = ee_valid ? {5'h0, a} : ~{4'h0, step};
        ee_data = (ee_valid && a != 3'h7) ? image[8 * (a - 3'h1) +: 8] : {step, ~step};
    end
endmodule : msahf_ee_model
`default_nettype wire

//--- verilog/msahf_fifo.sv
/*
 * Result queue of the address filter: a flip-flop FIFO with valid and ready.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module msahf_fifo #(
    parameter int WIDTH = 55,
    parameter int DEPTH = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } msahf_fifo_s;

    msahf_fifo_s s;
    msahf_fifo_s next_s;
    logic push;
    logic pop;

    assign in_ready = s.cnt != (AW + 1)'(DEPTH);
    assign out_valid = s.cnt != '0;
    assign out_data = s.mem[s.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : msahf_fifo
`default_nettype wire

//--- verilog/msahf_pkg.sv
/*
 * Constants and types shared by the station address and group filter block.
 * Assumes a 32-bit register bus with one aligned word per register index.
 */
`default_nettype none
package msahf_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [3:0] IDX_STATUS = 4'h0;
    localparam logic [3:0] IDX_CONTROL = 4'h1;
    localparam logic [3:0] IDX_SA_UPPER = 4'h2;
    localparam logic [3:0] IDX_SA_LOWER = 4'h3;
    localparam logic [3:0] IDX_GF_UPPER = 4'h4;
    localparam logic [3:0] IDX_GF_LOWER = 4'h5;

    // Control and status bit positions.
    localparam int CTRL_RX_ON_BIT = 2;
    localparam int CTRL_PASS_ALL_BIT = 4;
    localparam int STAT_INIT_DONE_BIT = 0;
    localparam int STAT_EE_LOADED_BIT = 1;
    localparam int STAT_STALLED_BIT = 2;

    // Values after reset.
    localparam logic [15:0] SA_UPPER_RST = 16'hffff;
    localparam logic [31:0] SA_LOWER_RST = 32'h0fffffff;
    localparam logic [31:0] GF_RST = 32'h00000000;

    // EEPROM bytes that carry the station address.
    localparam logic [7:0] EE_SA_FIRST = 8'h01;
    localparam logic [7:0] EE_SA_LAST = 8'h06;

    // CRC-32 used for the group hash index.
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam int CRC_IDX_LSB = 26;

    // Destination address length and result queue shape.
    localparam logic [2:0] DA_LAST_BYTE = 3'd5;
    localparam int RES_W = 55;
    localparam int RES_DEPTH = 32;

    typedef enum logic [1:0] {
        fs_idle,
        fs_addr,
        fs_push,
        fs_skip
    } msahf_fs_e;

endpackage : msahf_pkg
`default_nettype wire

//--- verilog/msahf_top.sv
/*
 * Station address and group hash filter of the MAC receive path, with its
 * AHB-Lite register slave, power-on address load and queued filter results.
 * Assumes single-word AHB-Lite transfers, an EEPROM controller that offers
 * address bytes before it signals completion, and a receive byte stream.
 */
`timescale 1ns/1ps
`default_nettype none
module msahf_top #(
    parameter int RES_DEPTH = msahf_pkg::RES_DEPTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ee_valid,
    input wire logic [7:0] ee_addr,
    input wire logic [7:0] ee_data,
    input wire logic ee_programmed,
    input wire logic ee_done,
    output logic init_done,
    output logic mac_receiver_on,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_first,
    input wire logic rx_last,
    output logic res_valid,
    input wire logic res_ready,
    output logic res_accept,
    output logic [5:0] res_hash_index,
    output logic [47:0] res_dest_addr
);
    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [3:0] wr_idx;
        logic ctrl_rx_on;
        logic ctrl_pass_all;
        logic [15:0] sa_upper;
        logic [31:0] sa_lower;
        logic [31:0] hash_upper;
        logic [31:0] hash_lower;
        logic init_done;
        logic ee_loaded;
        msahf_pkg::msahf_fs_e fs;
        logic [2:0] cnt;
        logic frame_en;
        logic mis;
        logic saw_last;
        logic [31:0] crc;
        logic [47:0] da;
        logic pend_accept;
        logic [5:0] pend_idx;
        logic rx_ready;
        logic res_valid;
        logic res_accept;
        logic [5:0] res_idx;
        logic [47:0] res_da;
    } msahf_state_s;

    msahf_state_s s;
    msahf_state_s next_s;

    logic addr_ok;
    logic take;
    logic decide;
    logic [47:0] sa_now;
    logic [63:0] hash_tbl;
    logic [31:0] crc_new;
    logic [5:0] idx_new;
    logic mis_new;
    logic [2:0] cmp_byte;
    logic [47:0] sa_wr;
    logic [2:0] ee_byte;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [msahf_pkg::RES_W-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [msahf_pkg::RES_W-1:0] fifo_out_data;

    function automatic logic [31:0] msahf_crc8(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ msahf_pkg::CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction : msahf_crc8

    // The first wire byte sits in the lowest byte of the combined address.
    assign sa_now = {s.sa_upper, s.sa_lower};
    assign hash_tbl = {s.hash_upper, s.hash_lower};
    assign addr_ok = hsel && htrans[1] && hready;
    assign take = rx_valid && s.rx_ready;
    assign decide = take && (s.fs == msahf_pkg::fs_addr) && (s.cnt == msahf_pkg::DA_LAST_BYTE);
    assign crc_new = msahf_crc8((s.fs == msahf_pkg::fs_addr) ? s.crc : msahf_pkg::CRC_INIT,
        rx_data);
    assign idx_new = crc_new[msahf_pkg::CRC_IDX_LSB +: 6];
    // A new frame compares its first byte against address byte zero, not a stale count.
    assign cmp_byte = (s.fs == msahf_pkg::fs_addr) ? s.cnt : 3'd0;
    assign mis_new = ((s.fs == msahf_pkg::fs_addr) && s.mis)
        || (rx_data != sa_now[8 * cmp_byte +: 8]);
    assign ee_byte = 3'(ee_addr - msahf_pkg::EE_SA_FIRST);

    assign fifo_in_valid = s.fs == msahf_pkg::fs_push;
    assign fifo_in_data = {s.pend_accept, s.pend_idx, s.da};
    assign fifo_out_ready = !s.res_valid || res_ready;

    always_comb begin
        next_s = s;
        sa_wr = {s.sa_upper, s.sa_lower};
        next_s.hreadyout = 1'b1;
        next_s.hresp = 1'b0;
        if (s.wr_pend) begin
            case (s.wr_idx)
                msahf_pkg::IDX_CONTROL: begin
                    next_s.ctrl_rx_on = hwdata[msahf_pkg::CTRL_RX_ON_BIT];
                    next_s.ctrl_pass_all = hwdata[msahf_pkg::CTRL_PASS_ALL_BIT];
                end
                msahf_pkg::IDX_SA_UPPER: sa_wr[47:32] = hwdata[15:0];
                msahf_pkg::IDX_SA_LOWER: sa_wr[31:0] = hwdata;
                msahf_pkg::IDX_GF_UPPER: next_s.hash_upper = hwdata;
                msahf_pkg::IDX_GF_LOWER: next_s.hash_lower = hwdata;
                default: begin
                end
            endcase
        end
        // Address bytes count only before the load completes and with a programmed part.
        if (ee_valid && ee_programmed && !s.init_done && (ee_addr >= msahf_pkg::EE_SA_FIRST)
            && (ee_addr <= msahf_pkg::EE_SA_LAST)) begin
            sa_wr[8 * ee_byte +: 8] = ee_data;
            next_s.ee_loaded = 1'b1;
        end
        next_s.sa_upper = sa_wr[47:32];
        next_s.sa_lower = sa_wr[31:0];
        if (ee_done) begin
            next_s.init_done = 1'b1;
        end
        next_s.wr_pend = addr_ok && hwrite;
        next_s.wr_idx = haddr[5:2];
        // Reads see the value after a write that completes at the same edge.
        if (addr_ok && !hwrite) begin
            case (haddr[5:2])
                msahf_pkg::IDX_STATUS: begin
                    next_s.hrdata = '0;
                    next_s.hrdata[msahf_pkg::STAT_INIT_DONE_BIT] = next_s.init_done;
                    next_s.hrdata[msahf_pkg::STAT_EE_LOADED_BIT] = next_s.ee_loaded;
                    next_s.hrdata[msahf_pkg::STAT_STALLED_BIT] = s.fs == msahf_pkg::fs_push;
                end
                msahf_pkg::IDX_CONTROL: begin
                    next_s.hrdata = '0;
                    next_s.hrdata[msahf_pkg::CTRL_RX_ON_BIT] = next_s.ctrl_rx_on;
                    next_s.hrdata[msahf_pkg::CTRL_PASS_ALL_BIT] = next_s.ctrl_pass_all;
                end
                msahf_pkg::IDX_SA_UPPER: next_s.hrdata = {16'h0000, next_s.sa_upper};
                msahf_pkg::IDX_SA_LOWER: next_s.hrdata = next_s.sa_lower;
                msahf_pkg::IDX_GF_UPPER: next_s.hrdata = next_s.hash_upper;
                msahf_pkg::IDX_GF_LOWER: next_s.hrdata = next_s.hash_lower;
                default: next_s.hrdata = '0;
            endcase
        end

        case (s.fs)
            msahf_pkg::fs_idle: begin
                if (take && rx_first) begin
                    next_s.frame_en = s.ctrl_rx_on;
                    next_s.crc = crc_new;
                    next_s.mis = mis_new;
                    next_s.da = {40'h0000000000, rx_data};
                    next_s.cnt = 3'd1;
                    next_s.fs = rx_last ? msahf_pkg::fs_idle : msahf_pkg::fs_addr;
                end
            end
            msahf_pkg::fs_addr: begin
                if (take) begin
                    next_s.crc = crc_new;
                    next_s.mis = mis_new;
                    next_s.da[8 * s.cnt +: 8] = rx_data;
                    next_s.cnt = s.cnt + 3'd1;
                    if (decide) begin
                        next_s.saw_last = rx_last;
                        next_s.pend_idx = idx_new;
                        if (s.da[0]) begin
                            // Top index bit picks the register, the rest the bit.
                            next_s.pend_accept = s.ctrl_pass_all
                                || hash_tbl[idx_new];
                        end else begin
                            next_s.pend_accept = !mis_new;
                        end
                        if (s.frame_en) begin
                            next_s.fs = msahf_pkg::fs_push;
                        end else begin
                            // A disabled receiver drops the frame without a result.
                            next_s.fs = rx_last ? msahf_pkg::fs_idle
                                : msahf_pkg::fs_skip;
                        end
                    end else if (rx_last) begin
                        next_s.fs = msahf_pkg::fs_idle;
                    end
                end
            end
            msahf_pkg::fs_push: begin
                if (fifo_in_ready) begin
                    next_s.fs = s.saw_last ? msahf_pkg::fs_idle : msahf_pkg::fs_skip;
                end
            end
            msahf_pkg::fs_skip: begin
                if (take && rx_last) begin
                    next_s.fs = msahf_pkg::fs_idle;
                end
            end
            default: next_s.fs = msahf_pkg::fs_idle;
        endcase
        next_s.rx_ready = next_s.fs != msahf_pkg::fs_push;

        if (fifo_out_ready) begin
            next_s.res_valid = fifo_out_valid;
            if (fifo_out_valid) begin
                next_s.res_accept = fifo_out_data[54];
                next_s.res_idx = fifo_out_data[53:48];
                next_s.res_da = fifo_out_data[47:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.hreadyout <= 1'b1;
            s.rx_ready <= 1'b1;
            s.sa_upper <= msahf_pkg::SA_UPPER_RST;
            s.sa_lower <= msahf_pkg::SA_LOWER_RST;
            s.hash_upper <= msahf_pkg::GF_RST;
            s.hash_lower <= msahf_pkg::GF_RST;
        end else begin
            s <= next_s;
        end
    end

    msahf_fifo #(
        .WIDTH(msahf_pkg::RES_W),
        .DEPTH(RES_DEPTH)
    ) u_res_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign hrdata = s.hrdata;
    assign init_done = s.init_done;
    assign mac_receiver_on = s.ctrl_rx_on;
    assign rx_ready = s.rx_ready;
    assign res_valid = s.res_valid;
    assign res_accept = s.res_accept;
    assign res_hash_index = s.res_idx;
    assign res_dest_addr = s.res_da;

    chk_rx_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && rx_first && s.fs == msahf_pkg::fs_idle && !s.ctrl_rx_on)
        |=> !fifo_in_valid [*6])
        else $error("Frame taken while receiver off produced a result.");

    chk_upper_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr[5:2] == msahf_pkg::IDX_SA_UPPER)
        |=> hrdata[31:16] == 16'h0000)
        else $error("Upper address read shows reserved bits.");

    chk_ee_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (ee_valid && !ee_programmed && !s.wr_pend)
        |=> $stable(s.sa_lower) && $stable(s.sa_upper))
        else $error("Address changed from an unprogrammed EEPROM.");

    chk_ee_lower: assert property (@(posedge hclk) disable iff (!hresetn)
        (ee_valid && ee_programmed && !s.init_done && ee_addr == 8'h02)
        |=> s.sa_lower[15:8] == $past(ee_data))
        else $error("EEPROM byte 0x02 did not reach lower bits 15:8.");

    chk_ee_upper: assert property (@(posedge hclk) disable iff (!hresetn)
        (ee_valid && ee_programmed && !s.init_done && ee_addr == 8'h06)
        |=> s.sa_upper[15:8] == $past(ee_data))
        else $error("EEPROM byte 0x06 did not reach upper bits 15:8.");

    chk_unicast_match: assert property (@(posedge hclk) disable iff (!hresetn)
        (decide && !s.da[0] && !s.wr_pend && !ee_valid)
        |=> s.pend_accept == (s.da == sa_now))
        else $error("Unicast decision disagrees with station address.");

    chk_hash_select: assert property (@(posedge hclk) disable iff (!hresetn)
        (decide && s.da[0] && !s.ctrl_pass_all && !s.wr_pend)
        |=> s.pend_accept == hash_tbl[s.pend_idx])
        else $error("Group decision disagrees with hash table bit.");

    chk_pass_all: assert property (@(posedge hclk) disable iff (!hresetn)
        (decide && s.da[0] && s.ctrl_pass_all && s.frame_en)
        |=> s.pend_accept && fifo_in_valid)
        else $error("Group frame refused while pass-all is set.");

    chk_init_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        init_done |=> init_done)
        else $error("Load-complete flag fell without a reset.");

endmodule : msahf_top
`default_nettype wire
